/* bench/crst_supplier.sv */
`timescale 1ns/1ps
// reset supplier standing on the far side of the reset sink
module crst_supplier
(
	// clock and request
	input  wire logic ref_clk,
	input  wire logic req,
	input  wire logic pol,
	// reset sink drive
	output logic      rst_raw,
	output logic      pol_out
);
	// level and polarity move together on the linked clock, no glitch
	always @(posedge ref_clk)
	begin
		rst_raw <= pol ? req : !req;
		pol_out <= pol;
	end
endmodule : crst_supplier

/* bench/crst_top_props.sv */
`timescale 1ns/1ps
module crst_top_props
	import crst_pkg::*;
#(
	parameter logic [31:0] CLOCK_FREQUENCY_HZ = CRST_CLOCK_HZ_DEFAULT,
	parameter logic [31:0] OUT_FREQUENCY_HZ   = CRST_CLOCK_HZ_DEFAULT,
	parameter int          STRETCH            = CRST_STRETCH_CYCLES
)
(
	// inputs
	input wire logic        ref_clk,
	input wire logic        rst_n,
	input wire logic        clk_en,
	input wire logic        rst_in_raw,
	input wire logic        rst_in_active_high,
	input wire crst_sync_t  reset_sync_setting,
	input wire logic        clk_div_en,
	// outputs
	input wire logic        clk_out,
	input wire logic        rst_out,
	input wire logic        rst_out_n,
	input wire logic        frequency_known_flag,
	input wire logic [31:0] clock_frequency_hz,
	input wire logic        in_reset
);
	logic sink_act;
	// sink level in active-high form
	assign sink_act = rst_in_raw ^ ~rst_in_active_high;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	AST_SRC_PAIR: assert property (rst_out_n == !rst_out)
		else $error("reset source outputs disagree");
	AST_FREQ: assert property ($past(rst_n, 2) |-> clock_frequency_hz == CLOCK_FREQUENCY_HZ)
		else $error("clock frequency value wrong");
	AST_KNOWN: assert property ($past(rst_n, 2) |-> frequency_known_flag == (OUT_FREQUENCY_HZ != 0))
		else $error("frequency known flag wrong");
	AST_SINK_ASSERT: assert property (sink_act && clk_en |-> ##[1:5] rst_out)
		else $error("reset source missed sink assertion");
	AST_SYNC_HOLD: assert property ($fell(sink_act) |-> rst_out [*3])
		else $error("reset released before synchroniser");
	AST_RELEASE: assert property ($fell(sink_act) |-> ##[4:20] !rst_out)
		else $error("reset source never released");
	AST_CLK_TOG: assert property (clk_en && $past(clk_div_en) && $past(clk_en) && $past(rst_n) |=> clk_out != $past(clk_out))
		else $error("clock source did not toggle");
	AST_FREEZE: assert property (!clk_en |=> $stable(rst_out) && $stable(clk_out))
		else $error("state moved while clock enable low");
	AST_BUSY: assert property (in_reset == rst_out)
		else $error("busy flag disagrees with reset source");
	// main scenarios
	COV_REL: cover property ($fell(rst_out));
	COV_ASS: cover property ($rose(rst_out));
	COV_FRZ: cover property (!clk_en && sink_act);
endmodule : crst_top_props
bind crst_top crst_top_props #(.CLOCK_FREQUENCY_HZ(CLOCK_FREQUENCY_HZ),
	.OUT_FREQUENCY_HZ(OUT_FREQUENCY_HZ), .STRETCH(STRETCH)) u_props (.ref_clk(ref_clk),
	.rst_n(rst_n), .clk_en(clk_en), .rst_in_raw(rst_in_raw), .clk_div_en(clk_div_en),
	.rst_in_active_high(rst_in_active_high), .reset_sync_setting(reset_sync_setting),
	.clk_out(clk_out), .rst_out(rst_out), .rst_out_n(rst_out_n), .in_reset(in_reset),
	.frequency_known_flag(frequency_known_flag), .clock_frequency_hz(clock_frequency_hz));

/* bench/testbench.sv */
`timescale 1ns/1ps
module testbench;
	import crst_pkg::*;
	localparam logic [31:0] FIN  = 32'h02fa_f080;
	localparam logic [31:0] FOUT = 32'h017d_7840;
	logic        ref_clk, rst_n, clk_en, req, pol, raw, clk_div_en, c0;
	logic        clk_out, rst_out, rst_out_n, fk, inr, pol_q;
	logic [31:0] fhz;
	crst_sync_t  sset;
	int          failures, num_checks;
	crst_top #(.CLOCK_FREQUENCY_HZ(FIN), .OUT_FREQUENCY_HZ(FOUT), .STRETCH(4)) dut (
		.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en), .rst_in_raw(raw),
		.rst_in_active_high(pol_q), .reset_sync_setting(sset), .clk_div_en(clk_div_en),
		.clk_out(clk_out), .rst_out(rst_out), .rst_out_n(rst_out_n),
		.frequency_known_flag(fk), .clock_frequency_hz(fhz), .in_reset(inr));
	crst_supplier u_sup (.ref_clk(ref_clk), .req(req), .pol(pol), .rst_raw(raw),
		.pol_out(pol_q));
	////////////////////////////////////////////////////////////////////////////////
	// clock
	initial
	begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end
	// compare and count
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			failures++;
			$display("BAD %s exp %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(negedge ref_clk);
	endtask : cyc
	task end_of_test;
		if (failures == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : end_of_test
	////////////////////////////////////////////////////////////////////////////////
	// watchdog
	initial
	begin
		repeat (2000) @(posedge ref_clk);
		failures++;
		end_of_test();
	end
	// main sequence
	initial
	begin
		rst_n = 1'b0;
		clk_en = 1'b1;
		req = 1'b1;
		pol = 1'b1;
		clk_div_en = 1'b0;
		sset = CRST_SYNC_DEASSERT;
		failures = 0;
		num_checks = 0;
		cyc(8);
		rst_n = 1'b1;
		cyc(20);
		chk("freq", fhz, FIN);
		chk("known", fk, 32'h1);
		chk("clk_off", clk_out, 32'h0);
		clk_div_en = 1'b1;
		cyc(1);
		c0 = clk_out;
		cyc(1);
		chk("clk_tog", clk_out, !c0);
		// every setting in both polarities
		for (int i = 0; i < 6; i++)
		begin
			req = 1'b1;
			cyc(10);
			sset = crst_sync_t'(2'(i % 3));
			pol = (i >= 3);
			cyc(4);
			chk("rst_on", rst_out, 32'h1);
			chk("busy", inr, 32'h1);
			req = 1'b0;
			cyc(3);
			chk("rst_hold", rst_out, 32'h1);
			cyc(20);
			chk("rst_off", rst_out, 32'h0);
			chk("rst_n_off", rst_out_n, 32'h1);
			chk("run", inr, 32'h0);
		end
		// frozen clock enable
		clk_en = 1'b0;
		req = 1'b1;
		cyc(6);
		chk("frozen", rst_out, 32'h0);
		clk_en = 1'b1;
		cyc(6);
		chk("thawed", rst_out, 32'h1);
		req = 1'b0;
		cyc(20);
		// system reset in mid-run
		rst_n = 1'b0;
		cyc(2);
		chk("sys_rst", rst_out, 32'h1);
		chk("sys_clk", clk_out, 32'h0);
		rst_n = 1'b1;
		cyc(20);
		chk("sys_rel", rst_out, 32'h0);
		chk("freq2", fhz, FIN);
		end_of_test();
	end
endmodule : testbench

/* rtl/crst_link_if.sv */
`timescale 1ns/1ps
// reset handed from the synchroniser to the sequencer
interface crst_link_if;
	logic sync_rst_n;
	logic raw_level;
	modport src (output sync_rst_n, output raw_level);
	modport dst (input sync_rst_n, input raw_level);
endinterface : crst_link_if

/* rtl/crst_pkg.sv */
package crst_pkg;

	// reset synchronisation settings of the incoming reset
	typedef enum logic [1:0]
	{
		CRST_SYNC_NONE     = 2'b00,
		CRST_SYNC_DEASSERT = 2'b01,
		CRST_SYNC_BOTH     = 2'b10
	} crst_sync_t;

	// reset sequencer states
	typedef enum logic [1:0]
	{
		CRST_ST_HOLD    = 2'b00,
		CRST_ST_STRETCH = 2'b01,
		CRST_ST_RUN     = 2'b10
	} crst_state_t;

	// default property values
	localparam logic [31:0] CRST_CLOCK_HZ_DEFAULT = 32'h0000_0000;
	localparam int          CRST_SYNC_STAGES      = 2;
	localparam int          CRST_STRETCH_CYCLES   = 4;
	localparam logic [3:0]  CRST_CNT_ZERO         = 4'h0;
	localparam logic [3:0]  CRST_CNT_ONE          = 4'h1;
	localparam logic [1:0]  CRST_DIV_ZERO         = 2'h0;
	localparam logic [1:0]  CRST_DIV_ONE          = 2'h1;

endpackage : crst_pkg

/* rtl/crst_reset_sync.sv */
`timescale 1ns/1ps
module crst_reset_sync
	import crst_pkg::*;
#(
	parameter int STAGES = CRST_SYNC_STAGES
)
(
	// clock and raw reset
	input  wire logic      ref_clk,
	input  wire logic      rst_n,
	input  wire logic      rst_in_raw,
	input  wire logic      rst_in_active_high,
	input  wire crst_sync_t reset_sync_setting,
	// synchronised result
	crst_link_if.src       link
);

	logic [STAGES-1:0] chain_reg;
	logic [STAGES-1:0] chain_next;
	logic              async_rst_n;
	logic              level_asserted;

	// polarity: active level of the incoming reset
	assign level_asserted = rst_in_active_high ? rst_in_raw : ~rst_in_raw; // R7
	// only setting DEASSERT/NONE lets the incoming reset clear the chain asynchronously
	assign async_rst_n = rst_n & ~(level_asserted & (reset_sync_setting != CRST_SYNC_BOTH));

	// chain shifts in released level, first stage read only by second
	always_comb
	begin
		chain_next = {chain_reg[STAGES-2:0], ~level_asserted};
	end

	// release passes every stage before reaching logic
	always_ff @(posedge ref_clk or negedge async_rst_n) // R2 R8 R15
	begin
		if (!async_rst_n)
			chain_reg <= '0;
		else
			chain_reg <= chain_next;
	end

	assign link.sync_rst_n = chain_reg[STAGES-1];
	assign link.raw_level  = level_asserted;

endmodule : crst_reset_sync

/* rtl/crst_top.sv */
// Contract
// R1 - each interface carries at most one signal per role, conduits excepted; reset source here drives both rst_out and rst_out_n
// R2 - logic reacts only to clock and reset edges; others sampled
// R3 - mandatory one-bit clock input times all logic
// R4 - clock input has frequency setting in hertz, zero meaning irrelevant
// R5 - clock source drives one-bit clock output with declared frequency
// R6 - mandatory one-bit reset input returns logic to chosen state
// R7 - reset may be active high or active low
// R8 - setting NONE: component synchronises incoming reset itself
// R9 - setting DEASSERT: supplier may assert async, must release synchronously
// R10 - setting BOTH: supplier asserts and releases synchronously
// R11 - DEASSERT or BOTH reset names its synchronising clock
// R12 - each synchronous interface has exactly one reference clock
// R13 - each synchronous interface has one named reset
// R14 - reset source drives one-bit reset output downstream
// R15 - released reset passes two flip-flops on linked clock
`timescale 1ns/1ps
module crst_top
	import crst_pkg::*;
#(
	parameter logic [31:0] CLOCK_FREQUENCY_HZ = CRST_CLOCK_HZ_DEFAULT,
	parameter logic [31:0] OUT_FREQUENCY_HZ   = CRST_CLOCK_HZ_DEFAULT,
	parameter int          STRETCH            = CRST_STRETCH_CYCLES
)
(
	// clock sink and system reset
	input  wire logic       ref_clk,
	input  wire logic       rst_n,
	input  wire logic       clk_en,
	// reset sink
	input  wire logic       rst_in_raw,
	input  wire logic       rst_in_active_high,
	input  wire crst_sync_t reset_sync_setting,
	// clock source
	input  wire logic       clk_div_en,
	output logic            clk_out,
	// reset source
	output logic            rst_out,
	output logic            rst_out_n,
	// property status
	output logic            frequency_known_flag,
	output logic [31:0]     clock_frequency_hz,
	output logic            in_reset
);

	crst_link_if link ();

	////////////////////////////////////////////////////////////////////////
	// reset sink synchroniser, linked to ref_clk

	crst_reset_sync #(
		.STAGES (CRST_SYNC_STAGES)
	) u_sync (
		.ref_clk            (ref_clk),
		.rst_n              (rst_n),
		.rst_in_raw         (rst_in_raw),
		.rst_in_active_high (rst_in_active_high),
		.reset_sync_setting (reset_sync_setting),
		.link               (link)
	); // R6 R11 R13

	// control pins are same-domain logic, sampled not edge used
	logic       div_en_reg,  div_en_next;

	////////////////////////////////////////////////////////////////////////
	// reset sequencer state

	crst_state_t state_reg, state_next;
	logic [3:0]  cnt_reg,   cnt_next;
	logic        rst_out_reg, rst_out_next;
	logic        clk_out_reg, clk_out_next;
	logic [1:0]  div_reg,   div_next;
	logic        known_reg, known_next;
	logic [31:0] freq_reg,  freq_next;
	logic        rst_out_n_reg, rst_out_n_next;
	logic        in_reset_reg,  in_reset_next;

	// plain pass-through of a sampled same-domain control level
	function automatic logic clk_en_sample(input logic v);
		clk_en_sample = v;
	endfunction : clk_en_sample

	// sequencer: hold while reset, stretch, then run
	always_comb
	begin
		state_next   = state_reg;
		cnt_next     = cnt_reg;
		rst_out_next = rst_out_reg;
		if (!link.sync_rst_n) // R6 R13
		begin
			state_next   = CRST_ST_HOLD;
			cnt_next     = CRST_CNT_ZERO;
			rst_out_next = 1'b1;
		end
		else
		begin
			case (state_reg)
				CRST_ST_HOLD:
				begin
					state_next = CRST_ST_STRETCH;
					cnt_next   = CRST_CNT_ZERO;
				end
				CRST_ST_STRETCH:
				begin
					if (cnt_reg == 4'(STRETCH - 1))
					begin
						state_next   = CRST_ST_RUN;
						rst_out_next = 1'b0; // R14
					end
					else
						cnt_next = cnt_reg + CRST_CNT_ONE;
				end
				CRST_ST_RUN:
					rst_out_next = 1'b0;
				default:
				begin
					state_next   = CRST_ST_HOLD;
					rst_out_next = 1'b1;
				end
			endcase
		end
	end

	// clock source: divide-by-two toggle when enabled
	always_comb
	begin
		div_en_next  = clk_en_sample(clk_div_en);
		div_next     = div_reg;
		clk_out_next = clk_out_reg;
		if (div_en_reg)
		begin
			div_next     = div_reg + CRST_DIV_ONE;
			clk_out_next = ~clk_out_reg; // R5
		end
		else
		begin
			div_next     = CRST_DIV_ZERO;
			clk_out_next = 1'b0;
		end
	end

	// frequency properties: zero marks rate as not significant
	always_comb
	begin
		freq_next  = CLOCK_FREQUENCY_HZ; // R4
		known_next = (OUT_FREQUENCY_HZ != CRST_CLOCK_HZ_DEFAULT);
	end

	// complement and busy flag registered so outputs come from flops
	always_comb
	begin
		rst_out_n_next = ~rst_out_next; // R7
		in_reset_next  = (state_next != CRST_ST_RUN); // R13
	end

	////////////////////////////////////////////////////////////////////////
	// registers, all timed by the one clock sink, frozen by clk_en

	always_ff @(posedge ref_clk or negedge rst_n) // R2 R3 R12
	begin
		if (!rst_n)
		begin
			state_reg   <= CRST_ST_HOLD;
			cnt_reg     <= CRST_CNT_ZERO;
			rst_out_reg <= 1'b1;
			clk_out_reg <= 1'b0;
			div_reg     <= CRST_DIV_ZERO;
			div_en_reg  <= 1'b0;
			known_reg   <= 1'b0;
			freq_reg    <= CRST_CLOCK_HZ_DEFAULT;
			rst_out_n_reg <= 1'b0;
			in_reset_reg  <= 1'b1;
		end
		else if (clk_en)
		begin
			state_reg   <= state_next;
			cnt_reg     <= cnt_next;
			rst_out_reg <= rst_out_next;
			clk_out_reg <= clk_out_next;
			div_reg     <= div_next;
			div_en_reg  <= div_en_next;
			known_reg   <= known_next;
			freq_reg    <= freq_next;
			rst_out_n_reg <= rst_out_n_next;
			in_reset_reg  <= in_reset_next;
		end
	end

	// reset source interface carries two reset signals, rst_out and rst_out_n
	assign rst_out              = rst_out_reg; // R1 R14
	assign rst_out_n            = rst_out_n_reg; // R7
	assign clk_out              = clk_out_reg;
	assign frequency_known_flag = known_reg;
	assign clock_frequency_hz   = freq_reg;
	assign in_reset             = in_reset_reg;

	// setting BOTH/DEASSERT supplier obligations relied on here: R9 R10

endmodule : crst_top
